// File: common/hef_pkg.sv
package hef_pkg;

  // register offsets on the parallel 8-bit register port
  localparam logic [7:0] OFF_EP0_CTRL  = 8'h00;
  localparam logic [7:0] OFF_FUNC_ADDR = 8'h01;
  localparam logic [7:0] OFF_INT       = 8'h02;
  localparam logic [7:0] OFF_MASK      = 8'h03;
  localparam logic [7:0] OFF_PID_LO    = 8'h04;
  localparam logic [7:0] OFF_PID_HI    = 8'h05;
  localparam logic [7:0] OFF_VID_LO    = 8'h06;
  localparam logic [7:0] OFF_VID_HI    = 8'h07;

  // endpoint 0 control register fields
  localparam int BIT_RX_EN = 0;
  localparam int BIT_TX_EN = 1;
  // function address register: enabled flag on top of the 7-bit address
  localparam int BIT_FUNC_EN = 7;

  // interrupt register fields
  localparam int INT_SETUP    = 0;
  localparam int INT_EP0RX    = 1;
  localparam int INT_EP0TX    = 2;
  localparam int INT_FUNC_RST = 3;
  localparam int INT_EP1_TX   = 4;
  localparam int INT_W        = 8;

  // bits a function reset leaves alone in the interrupt register
  localparam logic [7:0] INT_KEEP_ON_FUNC_RST = 8'h08;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [6:0] ADDR_ZERO  = 7'h00;
  localparam logic [3:0] EP_ZERO    = 4'h0;

  // standard request decode
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] REQTYPE_STD_OUT = 8'h00;
  localparam int         REQTYPE_DIR_BIT = 7;
  localparam logic [2:0] SETUP_IDX_TYPE  = 3'h0;
  localparam logic [2:0] SETUP_IDX_REQ   = 3'h1;
  localparam logic [2:0] SETUP_IDX_VALUE = 3'h2;
  localparam logic [2:0] SETUP_IDX_LAST  = 3'h7;

  // embedded function control-transfer stages
  typedef enum logic [1:0] {
    HEF_CT_IDLE   = 2'b00,
    HEF_CT_DATA   = 2'b01,
    HEF_CT_STATUS = 2'b11,
    HEF_CT_ADDR   = 2'b10
  } hef_ct_e;

endpackage

// File: hw/hef_irq.sv
`timescale 1ns/1ps
module hef_irq (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     func_rst_i,
  input  wire logic [hef_pkg::INT_W-1:0] set_i,
  input  wire logic [hef_pkg::INT_W-1:0] clr_i,
  input  wire logic [hef_pkg::INT_W-1:0] mask_i,
  output logic      [hef_pkg::INT_W-1:0] flags_o,
  output logic                          irq_o
);

  // one sticky flag per source; a set in the clear cycle wins
  for (genvar i = 0; i < hef_pkg::INT_W; i++) begin : g_flag
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        flags_o[i] <= 1'b0;
      end else if (set_i[i]) begin
        flags_o[i] <= 1'b1;
      end else if (clr_i[i]) begin
        flags_o[i] <= 1'b0;
      end else if (func_rst_i && !hef_pkg::INT_KEEP_ON_FUNC_RST[i]) begin
        flags_o[i] <= 1'b0;
      end
    end
  end

  // masked flags still latch so software can poll them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_o & mask_i);
    end
  end

endmodule

// File: hw/hef_setup_decode.sv
`timescale 1ns/1ps
module hef_setup_decode (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  output logic            done_o,
  output logic            set_addr_o,
  output logic            dir_in_o,
  output logic [6:0]      new_addr_o
);

  logic [2:0] idx_reg;
  logic [7:0] type_reg;
  logic [7:0] req_reg;

  // byte position within the eight-byte setup packet
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start_i) begin
      idx_reg <= hef_pkg::SETUP_IDX_TYPE;
    end else if (byte_valid_i) begin
      idx_reg <= idx_reg + 3'h1;
    end
  end

  // capture request type, request code and address value
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      type_reg   <= hef_pkg::RST_BYTE;
      req_reg    <= hef_pkg::RST_BYTE;
      new_addr_o <= hef_pkg::ADDR_ZERO;
    end else if (byte_valid_i && !start_i) begin
      if (idx_reg == hef_pkg::SETUP_IDX_TYPE) type_reg <= byte_i;
      if (idx_reg == hef_pkg::SETUP_IDX_REQ) req_reg <= byte_i;
      if (idx_reg == hef_pkg::SETUP_IDX_VALUE) new_addr_o <= byte_i[6:0];
    end
  end

  // done_o pulses one cycle after the last byte; set_addr_o and dir_in_o are held levels from the captured bytes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      done_o     <= 1'b0;
      set_addr_o <= 1'b0;
      dir_in_o   <= 1'b0;
    end else begin
      done_o     <= byte_valid_i && !start_i && idx_reg == hef_pkg::SETUP_IDX_LAST;
      set_addr_o <= type_reg == hef_pkg::REQTYPE_STD_OUT && req_reg == hef_pkg::REQ_SET_ADDRESS;
      dir_in_o   <= type_reg[hef_pkg::REQTYPE_DIR_BIT];
    end
  end

endmodule

// File: hw/hef_control.sv
`timescale 1ns/1ps
// Contract
// - identifier registers preloaded, microcontroller may overwrite
// - power-on reset gives stand-alone hub, defaults
// - addresses zero, function detached after power-up
// - attach only when both endpoint 0 enables set
// - hub works only once function attached
// - hub answers its own standard requests
// - answer NAK until function attached
// - pending condition sets bit; masked bits raise request
// - masked-off bits still set, no request
// - port reset sets function reset bit three
// - function reset waits for bit clear
// - function reset spares enables, reset bit, masks
// - bus reset touches hub logic only
// - port power on drives power output
// - port enable sets address register bit seven
// - hardware handles set-address, address readable after
// - other function requests go to microcontroller
// - control read: setup/status receive, data transmit
// - endpoint 1 bit follows its status sources
module hef_control #(
  parameter logic [7:0] PID_LO_DEFAULT = 8'h12, // arbitrary value
  parameter logic [7:0] PID_HI_DEFAULT = 8'h34, // arbitrary value
  parameter logic [7:0] VID_LO_DEFAULT = 8'h56, // arbitrary value
  parameter logic [7:0] VID_HI_DEFAULT = 8'h78  // arbitrary value
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        usb_bus_reset_i,
  input  wire logic        port5_power_i,
  input  wire logic        port5_enable_i,
  input  wire logic        port5_reset_i,
  input  wire logic        tok_setup_i,
  input  wire logic        tok_in_i,
  input  wire logic        tok_out_i,
  input  wire logic [6:0]  tok_addr_i,
  input  wire logic [3:0]  tok_ep_i,
  input  wire logic        setup_byte_valid_i,
  input  wire logic [7:0]  setup_byte_i,
  input  wire logic        xact_ack_i,
  input  wire logic [3:0]  ep1_status_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             irq_o,
  output logic             port5_power_on_out_o,
  output logic             attached_o,
  output logic             nak_o,
  output logic             hub_req_o,
  output logic             ep0_rx_route_o,
  output logic             ep0_tx_route_o,
  output logic             mcu_req_o,
  output logic      [6:0]  hub_addr_o,
  output logic      [6:0]  func_addr_o,
  output logic      [15:0] pid_o,
  output logic      [15:0] vid_o
);

  logic                     ep0_receive_enable_reg;
  logic                     ep0_transmit_enable_reg;
  logic                     function_enabled_flag_reg;
  logic                     func_rst_pend_reg;
  logic                     func_rst;
  logic [7:0]               mask_reg;
  logic [hef_pkg::INT_W-1:0] int_flags;
  logic [hef_pkg::INT_W-1:0] int_set;
  logic [hef_pkg::INT_W-1:0] int_clr;
  logic                     irq_int;
  logic                     dec_done;
  logic                     dec_set_addr;
  logic                     dec_dir_in;
  logic [6:0]               dec_addr;
  logic                     tok_any;
  logic                     hub_hit;
  logic                     func_hit;
  logic                     setup_for_hub_reg;
  logic                     hub_addr_pend_reg;
  logic [6:0]               hub_addr_new_reg;
  logic [6:0]               func_addr_new_reg;
  logic                     last_in_hw_reg;
  logic                     wr_int;
  hef_pkg::hef_ct_e         ct_reg;

  assign tok_any = tok_setup_i || tok_in_i || tok_out_i;
  // hub keeps priority while both sit at address zero
  assign hub_hit  = attached_o && tok_any && tok_addr_i == hub_addr_o;
  assign func_hit = attached_o && tok_any && !hub_hit && function_enabled_flag_reg
                    && tok_addr_i == func_addr_o && tok_ep_i == hef_pkg::EP_ZERO;
  assign wr_int   = reg_wr_i && reg_addr_i == hef_pkg::OFF_INT;

  // endpoint 0 enables and masks survive a function reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ep0_receive_enable_reg  <= 1'b0;
      ep0_transmit_enable_reg <= 1'b0;
      mask_reg                <= hef_pkg::RST_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == hef_pkg::OFF_EP0_CTRL) begin
        ep0_receive_enable_reg  <= reg_wdata_i[hef_pkg::BIT_RX_EN];
        ep0_transmit_enable_reg <= reg_wdata_i[hef_pkg::BIT_TX_EN];
      end
      if (reg_addr_i == hef_pkg::OFF_MASK) mask_reg <= reg_wdata_i;
    end
  end

  // identifiers: loaded only by power-on reset or a register write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pid_o <= {PID_HI_DEFAULT, PID_LO_DEFAULT};
      vid_o <= {VID_HI_DEFAULT, VID_LO_DEFAULT};
    end else if (reg_wr_i) begin
      if (reg_addr_i == hef_pkg::OFF_PID_LO) pid_o[7:0]  <= reg_wdata_i;
      if (reg_addr_i == hef_pkg::OFF_PID_HI) pid_o[15:8] <= reg_wdata_i;
      if (reg_addr_i == hef_pkg::OFF_VID_LO) vid_o[7:0]  <= reg_wdata_i;
      if (reg_addr_i == hef_pkg::OFF_VID_HI) vid_o[15:8] <= reg_wdata_i;
    end
  end

  // attach to port 5 needs both enables; firmware loads identifiers first
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      attached_o <= 1'b0;
    end else begin
      attached_o <= ep0_receive_enable_reg && ep0_transmit_enable_reg;
    end
  end

  // port state driven by the host through the hub; bus reset drops it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || usb_bus_reset_i) begin
      port5_power_on_out_o <= 1'b0;
    end else begin
      port5_power_on_out_o <= port5_power_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || func_rst) begin
      function_enabled_flag_reg <= 1'b0;
    end else begin
      function_enabled_flag_reg <= port5_enable_i && attached_o;
    end
  end

  // a port reset is held off until firmware clears the reset flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      func_rst_pend_reg <= 1'b0;
    end else if (port5_reset_i) begin
      func_rst_pend_reg <= 1'b1;
    end else if (func_rst) begin
      func_rst_pend_reg <= 1'b0;
    end
  end
  assign func_rst = func_rst_pend_reg && !int_flags[hef_pkg::INT_FUNC_RST]
                    && !port5_reset_i;

  // token dispatch: NAK while detached, hub or function otherwise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nak_o          <= 1'b0;
      hub_req_o      <= 1'b0;
      ep0_rx_route_o <= 1'b0;
      ep0_tx_route_o <= 1'b0;
    end else begin
      nak_o          <= tok_any && !attached_o;
      hub_req_o      <= hub_hit;
      ep0_rx_route_o <= func_hit && (tok_setup_i || tok_out_i);
      ep0_tx_route_o <= func_hit && tok_in_i && ct_reg != hef_pkg::HEF_CT_ADDR;
    end
  end

  // remember which logical device the current setup belongs to
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      setup_for_hub_reg <= 1'b0;
    end else if (tok_setup_i && attached_o) begin
      setup_for_hub_reg <= hub_hit;
    end
  end

  // control-transfer stage of the embedded function
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || func_rst) begin
      ct_reg <= hef_pkg::HEF_CT_IDLE;
    end else if (func_hit && tok_setup_i) begin
      ct_reg <= hef_pkg::HEF_CT_IDLE;
    end else begin
      unique case (ct_reg)
        hef_pkg::HEF_CT_IDLE: begin
          if (dec_done && !setup_for_hub_reg) begin
            if (dec_set_addr) ct_reg <= hef_pkg::HEF_CT_ADDR;
            else if (dec_dir_in) ct_reg <= hef_pkg::HEF_CT_DATA;
          end
        end
        hef_pkg::HEF_CT_DATA: begin
          if (func_hit && tok_out_i) ct_reg <= hef_pkg::HEF_CT_STATUS;
        end
        hef_pkg::HEF_CT_STATUS: begin
          if (xact_ack_i) ct_reg <= hef_pkg::HEF_CT_IDLE;
        end
        hef_pkg::HEF_CT_ADDR: begin
          if (xact_ack_i && last_in_hw_reg) ct_reg <= hef_pkg::HEF_CT_IDLE;
        end
      endcase
    end
  end

  // marks the zero-length status-in that hardware answers itself
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || func_rst) begin
      last_in_hw_reg <= 1'b0;
    end else if (tok_any) begin
      last_in_hw_reg <= func_hit && tok_in_i && ct_reg == hef_pkg::HEF_CT_ADDR;
    end
  end

  // function address changes only after the status stage is acknowledged, or to zero on a function reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || func_rst) begin
      func_addr_o       <= hef_pkg::ADDR_ZERO;
      func_addr_new_reg <= hef_pkg::ADDR_ZERO;
    end else begin
      if (dec_done && !setup_for_hub_reg) func_addr_new_reg <= dec_addr;
      if (ct_reg == hef_pkg::HEF_CT_ADDR && xact_ack_i && last_in_hw_reg) begin
        func_addr_o <= func_addr_new_reg;
      end
    end
  end

  // hub address: applied on the next xact_ack_i after the decoded setup, cleared by bus reset only on the hub side
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || usb_bus_reset_i) begin
      hub_addr_o        <= hef_pkg::ADDR_ZERO;
      hub_addr_new_reg  <= hef_pkg::ADDR_ZERO;
      hub_addr_pend_reg <= 1'b0;
    end else if (dec_done && setup_for_hub_reg) begin
      hub_addr_pend_reg <= dec_set_addr;
      hub_addr_new_reg  <= dec_addr;
    end else if (hub_addr_pend_reg && xact_ack_i) begin
      hub_addr_o        <= hub_addr_new_reg;
      hub_addr_pend_reg <= 1'b0;
    end
  end

  // any function request other than set-address goes to firmware
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mcu_req_o <= 1'b0;
    end else begin
      mcu_req_o <= dec_done && !setup_for_hub_reg && !dec_set_addr;
    end
  end

  // interrupt sources; endpoint 1 bit mirrors its status bits
  always_comb begin
    int_set = '0;
    int_set[hef_pkg::INT_SETUP] = dec_done && !setup_for_hub_reg && !dec_set_addr;
    int_set[hef_pkg::INT_EP0RX] = ep0_rx_route_o && !setup_for_hub_reg;
    int_set[hef_pkg::INT_EP0TX] = ep0_tx_route_o;
    int_set[hef_pkg::INT_FUNC_RST] = port5_reset_i;
    int_set[hef_pkg::INT_EP1_TX]   = |ep1_status_i;
    int_clr = wr_int ? reg_wdata_i : '0;
    int_clr[hef_pkg::INT_EP1_TX] = ~|ep1_status_i;
  end

  hef_irq u_irq (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .func_rst_i (func_rst),
    .set_i      (int_set),
    .clr_i      (int_clr),
    .mask_i     (mask_reg),
    .flags_o    (int_flags),
    .irq_o      (irq_int)
  );
  assign irq_o = irq_int;

  hef_setup_decode u_dec (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .start_i      (tok_setup_i),
    .byte_valid_i (setup_byte_valid_i),
    .byte_i       (setup_byte_i),
    .done_o       (dec_done),
    .set_addr_o   (dec_set_addr),
    .dir_in_o     (dec_dir_in),
    .new_addr_o   (dec_addr)
  );

  // registered read port; unmapped offsets read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= hef_pkg::RST_BYTE;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        hef_pkg::OFF_EP0_CTRL: begin
          reg_rdata_o <= ep0_ctrl_byte(ep0_receive_enable_reg, ep0_transmit_enable_reg);
        end
        hef_pkg::OFF_FUNC_ADDR: reg_rdata_o <= {function_enabled_flag_reg, func_addr_o};
        hef_pkg::OFF_INT:       reg_rdata_o <= int_flags;
        hef_pkg::OFF_MASK:      reg_rdata_o <= mask_reg;
        hef_pkg::OFF_PID_LO:    reg_rdata_o <= pid_o[7:0];
        hef_pkg::OFF_PID_HI:    reg_rdata_o <= pid_o[15:8];
        hef_pkg::OFF_VID_LO:    reg_rdata_o <= vid_o[7:0];
        hef_pkg::OFF_VID_HI:    reg_rdata_o <= vid_o[15:8];
        default:                reg_rdata_o <= hef_pkg::RST_BYTE;
      endcase
    end
  end

  function automatic logic [7:0] ep0_ctrl_byte(input logic rx, input logic tx);
    logic [7:0] v;
    v = hef_pkg::RST_BYTE;
    v[hef_pkg::BIT_RX_EN] = rx;
    v[hef_pkg::BIT_TX_EN] = tx;
    return v;
  endfunction

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_nak_detached: assert property (tok_any && !attached_o |=> nak_o)
    else $error("token while detached not answered with nak");
  a_attach_both: assert property (attached_o |-> $past(ep0_receive_enable_reg)
    && $past(ep0_transmit_enable_reg))
    else $error("attached without both enables");
  a_func_rst_set: assert property (port5_reset_i
    |=> int_flags[hef_pkg::INT_FUNC_RST])
    else $error("port reset did not set reset flag");
  // function state must not move while the reset flag is still up
  a_func_rst_hold: assert property (func_rst_pend_reg
    && int_flags[hef_pkg::INT_FUNC_RST] && !xact_ack_i |=> $stable(func_addr_o))
    else $error("function reset ran before flag cleared");
  // a register write in the reset cycle may change kept state on purpose
  a_func_rst_keep: assert property (func_rst && !reg_wr_i
    |=> $stable(mask_reg) && attached_o == $past(attached_o))
    else $error("function reset disturbed kept state");
  a_irq_mask: assert property (##1 irq_o == $past(|(int_flags & mask_reg)))
    else $error("request output does not follow masked flags");
  a_irq_poll: assert property (mask_reg == 8'h00 ##1 mask_reg == 8'h00 |-> !irq_o)
    else $error("request raised with all masks clear");
  a_id_stable: assert property (!reg_wr_i && (usb_bus_reset_i || func_rst)
    |=> $stable(pid_o) && $stable(vid_o))
    else $error("identifier changed by a non power-on reset");
  a_bus_rst_func: assert property (usb_bus_reset_i && !func_rst && !xact_ack_i
    |=> $stable(func_addr_o))
    else $error("bus reset changed function address");
  a_power_out: assert property (port5_power_i && !usb_bus_reset_i
    |=> port5_power_on_out_o)
    else $error("port power not reflected");
  a_ep1_mirror: assert property (|ep1_status_i |=> int_flags[hef_pkg::INT_EP1_TX])
    else $error("endpoint 1 bit not set by status");

  c_attach: cover property (!attached_o ##1 attached_o);
  c_func_reset: cover property (port5_reset_i ##[1:50] func_rst);
  c_set_addr: cover property (ct_reg == hef_pkg::HEF_CT_ADDR ##[1:100]
    func_addr_o != hef_pkg::ADDR_ZERO);
  c_ctrl_read: cover property (ct_reg == hef_pkg::HEF_CT_DATA ##[1:100]
    ct_reg == hef_pkg::HEF_CT_STATUS);

endmodule

// File: sim/hef_host_model.sv
`timescale 1ns/1ps
// host and hub side: port events, tokens and setup bytes, strobes last one cycle
module hef_host_model (
  input  wire logic       ref_clk_i,
  output logic            bus_rst_o,
  output logic            prst_o,
  output logic            ack_o,
  output logic            pwr_o,
  output logic            en_o,
  output logic [2:0]      tok_o,
  output logic [6:0]      addr_o,
  output logic [3:0]      ep_o,
  output logic            bv_o,
  output logic [7:0]      byte_o
);
  logic [2:0] ev;
  assign {ack_o, prst_o, bus_rst_o} = ev;

  initial begin
    ev = 3'h0;
    {pwr_o, en_o, tok_o, addr_o, ep_o, bv_o} = '0;
    byte_o = 8'h00;
  end

  // token kinds: bit0 setup, bit1 in, bit2 out; address is inverted afterwards
  task automatic tok(input logic [2:0] k, input logic [6:0] a, input logic [3:0] e);
    @(posedge ref_clk_i) #1;
    tok_o = k;
    addr_o = a;
    ep_o = e;
    @(posedge ref_clk_i) #1;
    tok_o = 3'h0;
    addr_o = ~a;
  endtask

  // setup token then eight bytes, first byte in the top lane
  task automatic setup(input logic [6:0] a, input logic [63:0] d);
    tok(3'h1, a, 4'h0);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk_i) #1;
      bv_o = 1'b1;
      byte_o = d[i*8 +: 8];
    end
    @(posedge ref_clk_i) #1;
    bv_o = 1'b0;
    byte_o = ~byte_o; // released lane shows no stale byte
  endtask

  // single-cycle events: 0 bus reset, 1 port reset, 2 transaction ack
  task automatic pulse(input int w);
    @(posedge ref_clk_i) #1;
    ev[w] = 1'b1;
    @(posedge ref_clk_i) #1;
    ev = 3'h0;
  endtask

  task automatic port(input logic p, input logic e);
    @(posedge ref_clk_i) #1;
    pwr_o = p;
    en_o = e;
  endtask
endmodule

// File: sim/hef_control_test.sv
`timescale 1ns/1ps
module hef_control_test;
  localparam logic [31:0] DFLT = 32'hd4c3b2a1; // arbitrary identifier defaults
  logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, rdata;
  logic [3:0]  ep1_status_i;
  logic        bus_rst, prst, ack, pwr, en, bv;
  logic [2:0]  tok;
  logic [6:0]  taddr, hub_addr, func_addr;
  logic [3:0]  tep;
  logic [7:0]  sbyte, reg_rdata;
  logic        irq, pwr_out, attached, nak, hub_req, rx, tx, mcu;
  logic [15:0] pid, vid;
  int          num_errors, checks;
  int          cnt[5];

  hef_host_model i_hef_host_model (.ref_clk_i(ref_clk_i), .bus_rst_o(bus_rst), .prst_o(prst),
    .ack_o(ack), .pwr_o(pwr), .en_o(en), .tok_o(tok), .addr_o(taddr), .ep_o(tep),
    .bv_o(bv), .byte_o(sbyte));

  hef_control #(.PID_LO_DEFAULT(DFLT[7:0]), .PID_HI_DEFAULT(DFLT[15:8]),
    .VID_LO_DEFAULT(DFLT[23:16]), .VID_HI_DEFAULT(DFLT[31:24])) i_hef_control (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .usb_bus_reset_i(bus_rst), .port5_power_i(pwr),
    .port5_enable_i(en), .port5_reset_i(prst), .tok_setup_i(tok[0]), .tok_in_i(tok[1]),
    .tok_out_i(tok[2]), .tok_addr_i(taddr), .tok_ep_i(tep), .setup_byte_valid_i(bv),
    .setup_byte_i(sbyte), .xact_ack_i(ack), .ep1_status_i(ep1_status_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata), .irq_o(irq), .port5_power_on_out_o(pwr_out),
    .attached_o(attached), .nak_o(nak), .hub_req_o(hub_req), .ep0_rx_route_o(rx),
    .ep0_tx_route_o(tx), .mcu_req_o(mcu), .hub_addr_o(hub_addr), .func_addr_o(func_addr),
    .pid_o(pid), .vid_o(vid));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // one-cycle answers are counted at every edge so none slips by unseen
  always @(posedge ref_clk_i) begin
    if (nak === 1'b1) cnt[0]++;
    if (hub_req === 1'b1) cnt[1]++;
    if (rx === 1'b1) cnt[2]++;
    if (tx === 1'b1) cnt[3]++;
    if (mcu === 1'b1) cnt[4]++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #1;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge ref_clk_i) #1;
    reg_wr_i = 1'b0;
    reg_wdata_i = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) #1;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge ref_clk_i) #1;
    reg_rd_i = 1'b0;
    d = reg_rdata;
  endtask

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic chk(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a, rdata);
    cmp(n, {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic cnts(input int nk, input int hb, input int r, input int t, input int m);
    cmp("nak count", 16'(nk), 16'(cnt[0]));
    cmp("hub count", 16'(hb), 16'(cnt[1]));
    cmp("rx count", 16'(r), 16'(cnt[2]));
    cmp("tx count", 16'(t), 16'(cnt[3]));
    cmp("mcu count", 16'(m), 16'(cnt[4]));
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // whole sequence is well under a thousand cycles
  initial begin
    #50us;
    num_errors++;
    end_sim();
  end

  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, ep1_status_i} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 4; i++) chk("id default", 8'(4 + i), DFLT[i*8 +: 8]);
    chk("func addr", 8'h01, 8'h00);
    chk("unmapped", 8'h20, 8'h00);
    cmp("attached", 16'h0, {15'h0, attached});
    cmp("hub addr reset", 16'h0, {9'h0, hub_addr});
    i_hef_host_model.tok(3'h2, 7'h00, 4'h0);
    cyc(2);
    cnts(1, 0, 0, 0, 0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) wr(8'(4 + i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++) chk("id custom", 8'(4 + i), 8'(8'h11 * (i + 1)));
    cmp("pid", 16'h2211, pid);
    cmp("vid", 16'h4433, vid);
    wr(8'h00, 8'h01);
    cyc(2);
    cmp("attached rx only", 16'h0, {15'h0, attached});
    wr(8'h00, 8'h03);
    cyc(2);
    cmp("attached", 16'h1, {15'h0, attached});
    i_hef_host_model.port(1'b1, 1'b1);
    cyc(3);
    cmp("power out", 16'h1, {15'h0, pwr_out});
    chk("func enabled", 8'h01, 8'h80);
    $display("test attach done");
    // hub enumerates first, then the function at address zero takes 2a
    i_hef_host_model.setup(7'h00, 64'h0005_1100_0000_0000);
    i_hef_host_model.tok(3'h2, 7'h00, 4'h0);
    i_hef_host_model.pulse(2);
    cyc(3);
    cmp("hub addr", 16'h0011, {9'h0, hub_addr});
    cnts(1, 2, 0, 0, 0);
    i_hef_host_model.setup(7'h00, 64'h0005_2a00_0000_0000);
    i_hef_host_model.tok(3'h2, 7'h00, 4'h0);
    i_hef_host_model.pulse(2);
    cyc(3);
    cmp("func addr", 16'h002a, {9'h0, func_addr});
    chk("func addr reg", 8'h01, 8'haa);
    cnts(1, 2, 1, 0, 0);
    // control read: setup, in data, out status, plus a stray endpoint 1 token
    i_hef_host_model.setup(7'h2a, 64'h8006_0001_0000_1200);
    cyc(3);
    i_hef_host_model.tok(3'h2, 7'h2a, 4'h0);
    i_hef_host_model.tok(3'h4, 7'h2a, 4'h0);
    i_hef_host_model.tok(3'h2, 7'h2a, 4'h1);
    cyc(2);
    cnts(1, 2, 3, 1, 1);
    rd(8'h02, rdata);
    cmp("setup int", 16'h1, {15'h0, rdata[0]});
    $display("test enumeration done");
    wr(8'h02, 8'hff);
    wr(8'h03, 8'h00);
    i_hef_host_model.pulse(1);
    cyc(3);
    chk("int func reset", 8'h02, 8'h08);
    cmp("irq masked", 16'h0, {15'h0, irq});
    wr(8'h03, 8'h08);
    cyc(3);
    cmp("irq", 16'h1, {15'h0, irq});
    cyc(5);
    cmp("addr held", 16'h002a, {9'h0, func_addr});
    wr(8'h00, 8'h03);
    wr(8'h02, 8'h08);
    cyc(3);
    cmp("addr reset", 16'h0, {9'h0, func_addr});
    cmp("irq clear", 16'h0, {15'h0, irq});
    chk("ep0 kept", 8'h00, 8'h03);
    chk("mask kept", 8'h03, 8'h08);
    chk("int after", 8'h02, 8'h00);
    cmp("pid kept", 16'h2211, pid);
    $display("test function reset done");
    wr(8'h03, 8'h10);
    ep1_status_i = 4'h2;
    cyc(3);
    chk("ep1 int", 8'h02, 8'h10);
    cmp("ep1 irq", 16'h1, {15'h0, irq});
    wr(8'h02, 8'h10);
    chk("ep1 held", 8'h02, 8'h10);
    ep1_status_i = 4'h0;
    cyc(3);
    chk("ep1 gone", 8'h02, 8'h00);
    cmp("ep1 irq off", 16'h0, {15'h0, irq});
    i_hef_host_model.pulse(0);
    cyc(3);
    cmp("hub addr bus rst", 16'h0, {9'h0, hub_addr});
    cmp("attached bus rst", 16'h1, {15'h0, attached});
    cmp("vid bus rst", 16'h4433, vid);
    chk("ep0 bus rst", 8'h00, 8'h03);
    $display("test interrupts and bus reset done");
    end_sim();
  end
endmodule
